/* core/fcpwm_consts.svh */
`ifndef FCPWM_CONSTS_SVH
`define FCPWM_CONSTS_SVH

// register indices on the write port
`define FCPWM_IDX_CFG 6'h24
`define FCPWM_IDX_DUTY0 6'h25
`define FCPWM_IDX_SHIFT0 6'h29
`define FCPWM_IDX_PULSE_POS 6'h2d
`define FCPWM_IDX_PULSE_LEN 6'h2e
`define FCPWM_NUM_CH 4

// reset values of the write-only registers
`define FCPWM_CFG_RST 64'h0
`define FCPWM_VAL12_RST 12'h0
`define FCPWM_LEN_RST 8'h0

// clock rates, in MHz, for the dead time conversion
`define FCPWM_CLK_MHZ 18'h7d
`define FCPWM_DT_CLK_MHZ 18'h64

// alignment codes
`define FCPWM_ALIGN_LEFT 2'h0
`define FCPWM_ALIGN_RIGHT 2'h1

// chopper codes
`define FCPWM_CHOP_COMPL 3'h0
`define FCPWM_CHOP_HS_ONLY 3'h1
`define FCPWM_CHOP_LS_ONLY 3'h2

`endif

/* core/fcpwm_pkg.sv */
package fcpwm_pkg;

	// layout of the 64-bit modulator configuration word
	typedef struct packed {
		logic [7:0] dead_time_hs;
		logic [7:0] dead_time_ls;
		logic rsv47;
		logic pol_zero;
		logic pol_a;
		logic pol_centre;
		logic pol_b;
		logic pol_ab;
		logic pol_hs;
		logic pol_ls;
		logic [5:0] rsv39;
		logic [1:0] align;
		logic [3:0][3:0] chop_nib;
		logic [3:0] rsv15;
		logic [11:0] max_count;
	} fcpwm_cfg_s;

	// trigger pulse outputs
	typedef struct packed {
		logic ab;
		logic b;
		logic centre;
		logic a;
		logic zero;
	} fcpwm_trig_s;

	// dead time sequencer states
	typedef enum logic [1:0] {
		ST_LS_ON,
		ST_GAP_HS,
		ST_HS_ON,
		ST_GAP_LS
	} fcpwm_dt_state_e;

endpackage

/* core/fcpwm_dead_time.sv */
`include "fcpwm_consts.svh"

module fcpwm_dead_time (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// request from the modulator
	input wire logic want_hs,
	input wire logic hs_en,
	input wire logic ls_en,
	// gaps in system clock cycles
	input wire logic [8:0] gap_hs,
	input wire logic [8:0] gap_ls,
	// switch commands
	output logic hs_on,
	output logic ls_on
);

	fcpwm_pkg::fcpwm_dt_state_e state_q, state_d;
	logic [8:0] cnt_q, cnt_d;

	// next state: both sides off for the gap before either turns on
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			fcpwm_pkg::ST_LS_ON:
				if (want_hs)
				begin
					cnt_d = gap_hs;
					state_d = (gap_hs == 9'h0) ? fcpwm_pkg::ST_HS_ON
						: fcpwm_pkg::ST_GAP_HS; // [R7]
				end
			fcpwm_pkg::ST_GAP_HS:
				if (!want_hs)
					state_d = fcpwm_pkg::ST_LS_ON; // high side never on
				else if (cnt_q <= 9'h1)
					state_d = fcpwm_pkg::ST_HS_ON; // [R7]
				else
					cnt_d = cnt_q - 9'h1;
			fcpwm_pkg::ST_HS_ON:
				if (!want_hs)
				begin
					cnt_d = gap_ls;
					state_d = (gap_ls == 9'h0) ? fcpwm_pkg::ST_LS_ON
						: fcpwm_pkg::ST_GAP_LS; // [R6]
				end
			fcpwm_pkg::ST_GAP_LS:
				if (want_hs)
					state_d = fcpwm_pkg::ST_HS_ON;
				else if (cnt_q <= 9'h1)
					state_d = fcpwm_pkg::ST_LS_ON; // [R6]
				else
					cnt_d = cnt_q - 9'h1;
		endcase
	end

	// state registers, reset into a safe off gap
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= fcpwm_pkg::ST_GAP_LS;
			cnt_q <= 9'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// chopper enables can only remove an on state
	assign hs_on = (state_q == fcpwm_pkg::ST_HS_ON) && hs_en;
	assign ls_on = (state_q == fcpwm_pkg::ST_LS_ON) && ls_en;

endmodule

/* core/fcpwm_top.sv */
// How it works
// R1 - each channel keeps its own 12-bit on-time value
// R2 - each channel has its own 3-bit chopper mode field
// R3 - one 2-bit alignment field at bits 33:32 governs all channels
// R4 - bit 40 inverts all low sides, bit 41 all high sides
// R5 - bits 42 to 46 set polarity of AB, B, centre, A, zero pulses
// R6 - low side turns on only after the programmed low-side gap
// R7 - high side turns on only after the programmed high-side gap
// R8 - one shared counter runs from zero to the 12-bit maximum count
// R9 - per-channel 12-bit shift moves both edges of that channel
// R10 - trigger pulses A and B fire at their own counter positions
// R11 - one 8-bit length sets duration of A, B, start, centre pulses
`include "fcpwm_consts.svh"

module fcpwm_top (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register write port
	input wire logic wr_en,
	input wire logic [5:0] wr_index,
	input wire logic [63:0] wr_data,
	// gate driver outputs
	output logic [3:0] hs_out,
	output logic [3:0] ls_out,
	// trigger pulses
	output fcpwm_pkg::fcpwm_trig_s trig_out
);

	// dead time in 100 MHz cycles to system cycles, rounded up
	function automatic logic [8:0] dt_to_clk(input logic [7:0] n);
		logic [17:0] prod;
		prod = {10'h0, n} * `FCPWM_CLK_MHZ + (`FCPWM_DT_CLK_MHZ - 18'h1);
		return 9'(prod / `FCPWM_DT_CLK_MHZ);
	endfunction

	// wrap a shifted count into the modulation period
	function automatic logic [11:0] wrap(input logic [11:0] c,
		input logic [11:0] sh, input logic [12:0] period);
		logic [12:0] sum;
		sum = {1'b0, c} + {1'b0, sh};
		if (sum >= period)
			sum = sum - period;
		return sum[11:0];
	endfunction

	fcpwm_pkg::fcpwm_cfg_s cfg_q, cfg_d;
	logic [3:0][11:0] duty_q, duty_d;
	logic [3:0][11:0] shift_q, shift_d;
	logic [11:0] pos_a_q, pos_a_d, pos_b_q, pos_b_d;
	logic [7:0] len_q, len_d;
	logic [11:0] cnt_q, cnt_d;
	logic up_q, up_d;
	logic [12:0] period;
	logic centre_mode;
	logic [3:0] want_hs, hs_en, ls_en, hs_on, ls_on;
	logic [8:0] gap_hs, gap_ls;
	logic [3:0] ev;
	logic [3:0][7:0] pc_q, pc_d;
	logic [3:0] act;
	logic [3:0] hs_out_d, ls_out_d;
	fcpwm_pkg::fcpwm_trig_s trig_d;

	// register writes, narrow registers take the low bits, except pos_b_d which takes bits 27:16
	always_comb
	begin
		cfg_d = cfg_q;
		duty_d = duty_q;
		shift_d = shift_q;
		pos_a_d = pos_a_q;
		pos_b_d = pos_b_q;
		len_d = len_q;
		if (wr_en)
		begin
			if (wr_index == `FCPWM_IDX_CFG)
				cfg_d = wr_data; // [R2] [R3] [R4] [R5] [R6] [R7] [R8]
			for (int i = 0; i < `FCPWM_NUM_CH; i++)
			begin
				if (wr_index == 6'(`FCPWM_IDX_DUTY0 + i))
					duty_d[i] = wr_data[11:0]; // [R1]
				if (wr_index == 6'(`FCPWM_IDX_SHIFT0 + i))
					shift_d[i] = wr_data[11:0]; // [R9]
			end
			if (wr_index == `FCPWM_IDX_PULSE_POS)
			begin
				pos_a_d = wr_data[11:0]; // [R10]
				pos_b_d = wr_data[27:16]; // [R10]
			end
			if (wr_index == `FCPWM_IDX_PULSE_LEN)
				len_d = wr_data[7:0]; // [R11]
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cfg_q <= `FCPWM_CFG_RST;
			duty_q <= '0;
			shift_q <= '0;
			pos_a_q <= `FCPWM_VAL12_RST;
			pos_b_q <= `FCPWM_VAL12_RST;
			len_q <= `FCPWM_LEN_RST;
		end
		else
		begin
			cfg_q <= cfg_d;
			duty_q <= duty_d;
			shift_q <= shift_d;
			pos_a_q <= pos_a_d;
			pos_b_q <= pos_b_d;
			len_q <= len_d;
		end
	end

	assign period = {1'b0, cfg_q.max_count} + 13'h1;
	assign centre_mode = cfg_q.align[1]; // [R3]

	// shared counter: sawtooth, or up-down triangle in centre mode
	always_comb
	begin
		cnt_d = cnt_q;
		up_d = up_q;
		if (!centre_mode || up_q)
		begin
			if (cnt_q >= cfg_q.max_count)
			begin
				cnt_d = 12'h0; // [R8]
				if (centre_mode && cfg_q.max_count != 12'h0)
				begin
					up_d = 1'b0;
					cnt_d = cfg_q.max_count - 12'h1;
				end
			end
			else
				cnt_d = cnt_q + 12'h1;
		end
		else if (cnt_q == 12'h0)
		begin
			up_d = 1'b1;
			cnt_d = (cfg_q.max_count == 12'h0) ? 12'h0 : 12'h1;
		end
		else
			cnt_d = cnt_q - 12'h1;
		if (!centre_mode)
			up_d = 1'b1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q <= 12'h0;
			up_q <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_d;
			up_q <= up_d;
		end
	end

	assign gap_hs = dt_to_clk(cfg_q.dead_time_hs); // [R7]
	assign gap_ls = dt_to_clk(cfg_q.dead_time_ls); // [R6]

	// per-channel compare, chopper steering and dead time
	genvar g;
	generate
		for (g = 0; g < `FCPWM_NUM_CH; g++)
		begin : gen_ch
			logic [11:0] eff;
			logic on;
			logic [2:0] chop;
			assign eff = wrap(cnt_q, shift_q[g], period); // [R9]
			assign chop = cfg_q.chop_nib[g][2:0]; // [R2]
			always_comb
			begin
				if (cfg_q.align == `FCPWM_ALIGN_RIGHT)
					on = ({1'b0, eff} + {1'b0, duty_q[g]}) >= period; // [R1]
				else
					on = eff < duty_q[g]; // [R1] [R3]
			end
			assign want_hs[g] = on;
			assign hs_en[g] = (chop == `FCPWM_CHOP_COMPL)
				|| (chop == `FCPWM_CHOP_HS_ONLY); // [R2]
			assign ls_en[g] = (chop == `FCPWM_CHOP_COMPL)
				|| (chop == `FCPWM_CHOP_LS_ONLY); // [R2]
			fcpwm_dead_time u_dt (
				.clk(clk),
				.rstn(rstn),
				.want_hs(want_hs[g]),
				.hs_en(hs_en[g]),
				.ls_en(ls_en[g]),
				.gap_hs(gap_hs),
				.gap_ls(gap_ls),
				.hs_on(hs_on[g]),
				.ls_on(ls_on[g])
			);
		end
	endgenerate

	// trigger events: a, b, zero (start), centre
	assign ev[0] = (cnt_q == pos_a_q); // [R10]
	assign ev[1] = (cnt_q == pos_b_q); // [R10]
	assign ev[2] = (cnt_q == 12'h0); // bottom of the count in every mode
	assign ev[3] = centre_mode ? (cnt_q == cfg_q.max_count)
		: (cnt_q == (cfg_q.max_count >> 1));

	// pulse stretchers, length at least one cycle
	generate
		for (g = 0; g < 4; g++)
		begin : gen_pulse
			always_comb
			begin
				if (ev[g])
					pc_d[g] = (len_q == 8'h0) ? 8'h1 : len_q; // [R11]
				else if (pc_q[g] != 8'h0)
					pc_d[g] = pc_q[g] - 8'h1;
				else
					pc_d[g] = 8'h0;
			end
			assign act[g] = (pc_q[g] != 8'h0);
		end
	endgenerate

	// polarity applied on the way into the output flops
	always_comb
	begin
		hs_out_d = hs_on ^ {4{cfg_q.pol_hs}}; // [R4]
		ls_out_d = ls_on ^ {4{cfg_q.pol_ls}}; // [R4]
		trig_d.a = act[0] ^ cfg_q.pol_a; // [R5]
		trig_d.b = act[1] ^ cfg_q.pol_b; // [R5]
		trig_d.zero = act[2] ^ cfg_q.pol_zero; // [R5]
		trig_d.centre = act[3] ^ cfg_q.pol_centre; // [R5]
		trig_d.ab = (act[0] | act[1]) ^ cfg_q.pol_ab; // [R5]
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pc_q <= '0;
			hs_out <= 4'h0;
			ls_out <= 4'h0;
			trig_out <= '0;
		end
		else
		begin
			pc_q <= pc_d;
			hs_out <= hs_out_d;
			ls_out <= ls_out_d;
			trig_out <= trig_d;
		end
	end

endmodule

/* dv/fcpwm_props.sv */
module fcpwm_props (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// write port
	input wire logic wr_en,
	input wire logic [5:0] wr_index,
	input wire logic [63:0] wr_data,
	// outputs
	input wire logic [3:0] hs_out,
	input wire logic [3:0] ls_out,
	input wire fcpwm_pkg::fcpwm_trig_s trig_out
);
	timeunit 1ns;
	timeprecision 1ps;
	fcpwm_pkg::fcpwm_cfg_s cfg_q;
	logic [11:0] duty_q;
	logic [3:0] wq_q;
	logic [8:0] hoff_q;
	logic [8:0] loff_q;
	logic [3:0] hs;
	logic [3:0] ls;
	logic [3:0] ho;
	logic [3:0] lo;
	logic [3:0] bo;
	logic [8:0] gls;
	logic [8:0] ghs;
	// switch view after polarity, gaps in system clocks
	assign hs = hs_out ^ {4{cfg_q.pol_hs}};
	assign ls = ls_out ^ {4{cfg_q.pol_ls}};
	assign gls = 9'((17'(cfg_q.dead_time_ls) * 17'h7d + 17'h63) / 17'h64);
	assign ghs = 9'((17'(cfg_q.dead_time_hs) * 17'h7d + 17'h63) / 17'h64);
	// chopper forcing per channel
	always_comb
		for (int k = 0; k < 4; k++)
		begin
			ho[k] = cfg_q.chop_nib[k][2:0] == 3'h1;
			lo[k] = cfg_q.chop_nib[k][2:0] == 3'h2;
			bo[k] = cfg_q.chop_nib[k][2:0] > 3'h2;
		end
	// shadow of writes, off-time counters of channel 0
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
		begin
			cfg_q <= '0;
			duty_q <= 12'h0;
			wq_q <= 4'h0;
			hoff_q <= 9'h0;
			loff_q <= 9'h0;
		end
		else
		begin
			wq_q <= {wq_q[2:0], wr_en};
			if (wr_en && wr_index == 6'h24)
				cfg_q <= wr_data;
			if (wr_en && wr_index == 6'h25)
				duty_q <= wr_data[11:0];
			hoff_q <= hs[0] ? 9'h0 : hoff_q + {8'h0, hoff_q != 9'h1ff};
			loff_q <= ls[0] ? 9'h0 : loff_q + {8'h0, loff_q != 9'h1ff};
		end
	a_no_overlap: assert property (@(posedge clk) disable iff (!rstn)
		wq_q == 4'h0 |-> (hs & ls) == 4'h0) else $error("both sides on");
	a_ls_gap: assert property (@(posedge clk) disable iff (!rstn)
		$rose(ls[0]) && wq_q == 4'h0 |-> hoff_q >= gls)
		else $error("low side gap short");
	a_hs_gap: assert property (@(posedge clk) disable iff (!rstn)
		$rose(hs[0]) && wq_q == 4'h0 |-> loff_q >= ghs)
		else $error("high side gap short");
	a_hs_only: assert property (@(posedge clk) disable iff (!rstn)
		wq_q == 4'h0 |-> (ls & ho) == 4'h0) else $error("low side on");
	a_ls_only: assert property (@(posedge clk) disable iff (!rstn)
		wq_q == 4'h0 |-> (hs & lo) == 4'h0) else $error("high side on");
	a_both_off: assert property (@(posedge clk) disable iff (!rstn)
		wq_q == 4'h0 |-> ((hs | ls) & bo) == 4'h0) else $error("side on");
	a_duty_zero: assert property (@(posedge clk) disable iff (!rstn)
		wq_q == 4'h0 && duty_q == 12'h0 |-> !hs[0]) else $error("duty 0 on");
	a_reset_idle: assert property (@(posedge clk) disable iff (!rstn)
		$rose(rstn) |-> ({hs_out, ls_out, trig_out} == 13'h0) [*2])
		else $error("outputs active after reset");
endmodule

/* dv/fcpwm_gate_model.sv */
module fcpwm_gate_model (
	// clock
	input wire logic clk,
	// gate commands
	input wire logic [3:0] hs_on,
	input wire logic [3:0] ls_on,
	// shoot-through events seen
	output int shorts
);
	timeunit 1ns;
	timeprecision 1ps;
	// a leg with both switches on shorts the supply, count starts at zero
	always @(negedge clk)
		if ((hs_on & ls_on) != 4'h0)
			shorts++;
endmodule

/* dv/fcpwm_tb.sv */
`include "fcpwm_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr_en = 1'b0;
	logic [5:0] wr_index = 6'h0;
	logic [63:0] wr_data = 64'h0;
	logic [3:0] hs_out;
	logic [3:0] ls_out;
	fcpwm_pkg::fcpwm_trig_s trig_out;
	int shorts;
	int c [14];
	int n_mismatch = 0;
	int num_checks = 0;
	// 125 MHz clock
	always #4 clk = ~clk;
	fcpwm_top DUT (.clk(clk), .rstn(rstn), .wr_en(wr_en),
		.wr_index(wr_index), .wr_data(wr_data), .hs_out(hs_out),
		.ls_out(ls_out), .trig_out(trig_out));
	fcpwm_gate_model bridge (.clk(clk), .hs_on(hs_out), .ls_on(ls_out),
		.shorts(shorts));
	// compare and count
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// reset held for four cycles
	task rst();
		@(posedge clk);
		#1;
		rstn = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		rstn = 1'b1;
		@(negedge clk);
		chk({hs_out, ls_out, trig_out}, 16'h0);
	endtask
	// one register write
	task wr(input logic [5:0] i, input logic [63:0] d);
		@(posedge clk);
		#1;
		wr_en = 1'b1;
		wr_index = i;
		wr_data = d;
		@(posedge clk);
		#1;
		wr_en = 1'b0;
	endtask
	// active cycles of every output over n cycles
	task run(input int n);
		c = '{default: 0};
		repeat (60) @(posedge clk);
		repeat (n)
		begin
			@(negedge clk);
			for (int k = 0; k < 4; k++)
			begin
				c[k] += hs_out[k];
				c[k + 4] += ls_out[k];
			end
			for (int k = 0; k < 5; k++)
				c[k + 8] += trig_out[k];
			c[13] += hs_out[0] & hs_out[1];
		end
	endtask
	// duties 0, 3, 6 and above max; an unmapped write is ignored
	task t_duty();
		int dt [4] = '{0, 3, 6, 12};
		rst();
		wr(`FCPWM_IDX_CFG, 64'h9);
		for (int k = 0; k < 4; k++)
			wr(`FCPWM_IDX_DUTY0 + 6'(k), 64'(dt[k]));
		wr(6'h2f, 64'hfff);
		run(100);
		for (int k = 0; k < 4; k++)
		begin
			chk(c[k], (dt[k] > 9 ? 10 : dt[k]) * 10);
			chk(c[k + 4], 100 - (dt[k] > 9 ? 10 : dt[k]) * 10);
		end
	endtask
	// chopper codes 1, 2, 3, 7
	task t_chop();
		rst();
		wr(`FCPWM_IDX_CFG, 64'h7321_0009);
		for (int k = 0; k < 4; k++)
			wr(`FCPWM_IDX_DUTY0 + 6'(k), 64'h5);
		run(100);
		chk(c[0] + c[5], 100);
		chk(c[1] + c[2] + c[3] + c[4] + c[6] + c[7], 0);
	endtask
	// channel 1 shifted by 3 against channel 0
	task t_shift();
		rst();
		wr(`FCPWM_IDX_CFG, 64'h9);
		wr(`FCPWM_IDX_DUTY0, 64'h5);
		wr(`FCPWM_IDX_DUTY0 + 6'h1, 64'h5);
		wr(`FCPWM_IDX_SHIFT0 + 6'h1, 64'h3);
		run(100);
		chk(c[1], 50);
		chk(c[13], 20);
	endtask
	// gaps of 5 and 10 system clocks
	task t_gap();
		rst();
		wr(`FCPWM_IDX_CFG, 64'h0804_0000_0000_0031);
		wr(`FCPWM_IDX_DUTY0, 64'h19);
		run(500);
		chk(c[0], 150);
		chk(c[4], 200);
	endtask
	// right and both centre codes
	task t_align();
		rst();
		wr(`FCPWM_IDX_DUTY0, 64'h3);
		for (int a = 1; a < 4; a++)
		begin
			wr(`FCPWM_IDX_CFG, {30'h0, 2'(a), 32'h9});
			run(180);
			chk(c[0], a == 1 ? 54 : 50);
			chk(c[8], a == 1 ? 18 : 10);
			chk(c[10], a == 1 ? 18 : 10);
		end
	endtask
	// trigger positions and length, then every polarity inverted
	task t_trig();
		rst();
		wr(`FCPWM_IDX_CFG, 64'h9);
		wr(`FCPWM_IDX_PULSE_POS, 64'h5_0002);
		wr(`FCPWM_IDX_PULSE_LEN, 64'h3);
		run(100);
		chk(c[9] + c[11], 60);
		chk(c[12], 60);
		chk(c[8] + c[10], 60);
		chk(shorts, 0);
		wr(`FCPWM_IDX_CFG, 64'h7f00_3333_0009);
		run(100);
		for (int k = 0; k < 8; k++)
			chk(c[k], 100);
		chk(c[8] + c[9] + c[10] + c[11], 280);
		chk(c[12], 40);
	endtask
	// verdict
	task close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		t_duty();
		t_chop();
		t_shift();
		t_gap();
		t_align();
		t_trig();
		close_out();
	end
endmodule
bind fcpwm_top fcpwm_props u_props (.clk(clk), .rstn(rstn), .wr_en(wr_en),
	.wr_index(wr_index), .wr_data(wr_data), .hs_out(hs_out),
	.ls_out(ls_out), .trig_out(trig_out));
